//--- rtl/cgrr_pkg.sv
package cgrr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  OFS_GAIN_SHARED  = 8'h00;
  localparam logic [7:0]  OFS_ROUTE_SHARED = 8'h04;
  localparam logic [7:0]  OFS_DAC_GAIN     = 8'h08;
  localparam logic [7:0]  OFS_SIDETONE     = 8'h0C;
  localparam logic [7:0]  OFS_SPEAKER      = 8'h10;
  localparam logic [7:0]  OFS_ROUTING      = 8'h14;
  localparam logic [7:0]  OFS_STATUS       = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // sub-register prefixes in bits 7:6 (routing uses bit 7 only)
  localparam logic [1:0]  PFX_ADC          = 2'h0;
  localparam logic [1:0]  PFX_DAC          = 2'h1;
  localparam logic [1:0]  PFX_SIDE         = 2'h2;
  localparam logic [1:0]  PFX_SPK          = 2'h3;
  localparam logic        PFX_ROUTE        = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          DAC_LSB          = 0;
  localparam int          AST_LSB          = 3;
  localparam int          DST_LSB          = 0;
  localparam int          SPK_LSB          = 4;
  localparam int          ROUTE_LSB        = 0;
  localparam int          STAT_DAC_LSB     = 0;
  localparam int          STAT_AST_LSB     = 8;
  localparam int          STAT_DST_LSB     = 14;
  localparam int          STAT_SPK_LSB     = 20;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [5:0]  RST_DAC_CODE     = 6'h00;
  localparam logic [2:0]  RST_SIDE_CODE    = 3'h0;
  localparam logic [1:0]  RST_SPK_CODE     = 2'h0;
  localparam logic [6:0]  RST_ROUTE        = 7'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // gain decode constants (dac in half-dB units, sidetone in dB)
  localparam logic [6:0]  DAC_STEP_HALF_DB = 7'h03;
  localparam logic [4:0]  DAC_LAST_STEP    = 5'h1B;
  localparam logic [4:0]  DAC_CODE_42      = 5'h1C;
  localparam logic [4:0]  DAC_CODE_48      = 5'h1D;
  localparam logic [4:0]  DAC_CODE_54      = 5'h1E;
  localparam logic [4:0]  DAC_MUTE_CODE    = 5'h1F;
  localparam logic [6:0]  DAC_ATT_42       = 7'h54;
  localparam logic [6:0]  DAC_ATT_48       = 7'h60;
  localparam logic [6:0]  DAC_ATT_54       = 7'h6C;
  localparam logic [4:0]  SIDE_BASE_DB     = 5'h09;
  localparam logic [4:0]  SIDE_STEP_DB     = 5'h03;
  localparam logic [2:0]  SIDE_MUTE_CODE   = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       mute;
    logic [6:0] atten_half_db;
  } cgrr_dac_type;

  typedef struct packed {
    logic       mute;
    logic [4:0] atten_db;
  } cgrr_side_type;

  typedef struct packed {
    logic headset_loopback;
    logic handset_loopback;
    logic caller_id_to_adc;
    logic line_to_adc;
    logic microphone_to_adc;
    logic handset_to_adc;
    logic headset_to_adc;
  } cgrr_route_type;

endpackage

//--- rtl/cgrr_dac_decode.sv
`timescale 1ns/1ps
module cgrr_dac_decode (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [5:0]            dac_attenuation_code,
  output cgrr_pkg::cgrr_dac_type     dac_path
);
  import cgrr_pkg::*;

  // bit 5 has no documented meaning; only the low five bits steer the path
  function automatic cgrr_dac_type dac_decode(input logic [4:0] code);
    cgrr_dac_type r;
    r.mute          = 1'b0;
    r.atten_half_db = 7'h00;
    if (code <= DAC_LAST_STEP) begin
      r.atten_half_db = 7'({2'h0, code} * DAC_STEP_HALF_DB);
    end else if (code == DAC_CODE_42) begin
      r.atten_half_db = DAC_ATT_42;
    end else if (code == DAC_CODE_48) begin
      r.atten_half_db = DAC_ATT_48;
    end else if (code == DAC_CODE_54) begin
      r.atten_half_db = DAC_ATT_54;
    end else begin
      r.mute          = 1'b1;
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_path <= dac_decode(RST_DAC_CODE[4:0]);
    end else begin
      dac_path <= dac_decode(dac_attenuation_code[4:0]);
    end
  end

endmodule

//--- rtl/cgrr_sidetone_decode.sv
`timescale 1ns/1ps
module cgrr_sidetone_decode (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [2:0]            level_code,
  output cgrr_pkg::cgrr_side_type    sidetone
);
  import cgrr_pkg::*;

  function automatic cgrr_side_type side_decode(input logic [2:0] code);
    cgrr_side_type r;
    r.mute     = (code == SIDE_MUTE_CODE);
    r.atten_db = 5'(SIDE_BASE_DB + 5'({2'h0, code} * SIDE_STEP_DB));
    if (r.mute) begin
      r.atten_db = 5'h00;
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sidetone <= side_decode(RST_SIDE_CODE);
    end else begin
      sidetone <= side_decode(level_code);
    end
  end

endmodule

//--- rtl/cgrr_regs.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cgrr_regs (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [cgrr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [cgrr_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [cgrr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [cgrr_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output cgrr_pkg::cgrr_dac_type        dac_path,
  output cgrr_pkg::cgrr_side_type       analog_sidetone,
  output cgrr_pkg::cgrr_side_type       digital_sidetone,
  output logic [1:0]                    speaker_boost,
  output cgrr_pkg::cgrr_route_type      input_route
);
  import cgrr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // stored fields

  logic [5:0]           dac_attenuation_code;
  logic [2:0]           analog_sidetone_level;
  logic [2:0]           digital_sidetone_level;
  cgrr_route_type       route_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // write channel state

  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic [3:0]           wr_strb;
  logic                 wr_go;
  logic                 wr_low_byte;
  logic [7:0]           wr_byte;
  logic                 wr_gain_hit;
  logic                 wr_route_hit;
  logic                 wr_ro_hit;
  logic                 next_write_dac;
  logic                 next_write_side;
  logic                 next_write_spk;
  logic                 next_write_route;
  logic [1:0]           next_bresp;

  ////////////////////////////////////////////////////////////////////////////////
  // read channel state

  logic [DATA_W-1:0]    next_rdata;
  logic [1:0]           next_rresp;

  // a word is mapped when it is aligned and lands on a known offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        ofs);
    return addr[1:0] == 2'h0 && {addr[ADDR_W-1:2], 2'h0} == ofs;
  endfunction

  // assembles the byte a sub-register presents, prefix included
  function automatic logic [DATA_W-1:0] pack_byte(input logic [1:0] pfx,
                                                  input logic [5:0] body);
    return {24'h000000, pfx, body};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // write address handshake

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_addr <= s_axi_awaddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write data handshake

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write decode

  // both halves held and no answer pending: exactly one cycle per write
  assign wr_go        = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_low_byte  = wr_strb[0];
  assign wr_byte      = wr_data[7:0];
  assign wr_gain_hit  = addr_is(wr_addr, OFS_GAIN_SHARED);
  assign wr_route_hit = addr_is(wr_addr, OFS_ROUTE_SHARED);
  assign wr_ro_hit    = addr_is(wr_addr, OFS_DAC_GAIN) || addr_is(wr_addr, OFS_SIDETONE)
                        || addr_is(wr_addr, OFS_SPEAKER) || addr_is(wr_addr, OFS_ROUTING)
                        || addr_is(wr_addr, OFS_STATUS);

  always_comb begin
    next_write_dac   = 1'b0;
    next_write_side  = 1'b0;
    next_write_spk   = 1'b0;
    next_write_route = 1'b0;
    next_bresp       = RESP_OKAY;
    if (wr_gain_hit) begin
      // prefix 00 belongs to the adc gain, which lives elsewhere
      if (wr_low_byte) begin
        case (wr_byte[7:6])
          PFX_DAC: begin
            next_write_dac = 1'b1;
          end
          PFX_SIDE: begin
            next_write_side = 1'b1;
          end
          PFX_SPK: begin
            next_write_spk = 1'b1;
          end
          default: begin
            next_write_dac = 1'b0;
          end
        endcase
      end
    end else if (wr_route_hit) begin
      // top bit 1 belongs to the output routing, also not held here
      if (wr_low_byte && wr_byte[7] == PFX_ROUTE) begin
        next_write_route = 1'b1;
      end
    end else if (wr_ro_hit) begin
      next_bresp = RESP_SLVERR;
    end else begin
      next_bresp = RESP_DECERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write response

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // code moves only on wr_go, so it holds while bready stalls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bresp <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gain fields

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_attenuation_code <= RST_DAC_CODE;
    end else if (wr_go && next_write_dac) begin
      dac_attenuation_code <= wr_byte[DAC_LSB +: 6];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_sidetone_level  <= RST_SIDE_CODE;
      digital_sidetone_level <= RST_SIDE_CODE;
    end else if (wr_go && next_write_side) begin
      analog_sidetone_level  <= wr_byte[AST_LSB +: 3];
      digital_sidetone_level <= wr_byte[DST_LSB +: 3];
    end
  end

  // reserved low nibble is never stored, so it cannot steer anything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speaker_boost <= RST_SPK_CODE;
    end else if (wr_go && next_write_spk) begin
      speaker_boost <= wr_byte[SPK_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input routing

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_bits <= RST_ROUTE;
    end else if (wr_go && next_write_route) begin
      route_bits <= wr_byte[ROUTE_LSB +: 7];
    end
  end

  // a separate flop keeps the output a register copy, one cycle behind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_route <= RST_ROUTE;
    end else begin
      input_route.headset_loopback  <= route_bits.headset_loopback;
      input_route.handset_loopback  <= route_bits.handset_loopback;
      input_route.caller_id_to_adc  <= route_bits.caller_id_to_adc;
      input_route.line_to_adc       <= route_bits.line_to_adc;
      input_route.microphone_to_adc <= route_bits.microphone_to_adc;
      input_route.handset_to_adc    <= route_bits.handset_to_adc;
      input_route.headset_to_adc    <= route_bits.headset_to_adc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gain decoders

  cgrr_dac_decode u_dac (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .dac_attenuation_code (dac_attenuation_code),
    .dac_path             (dac_path)
  );

  cgrr_sidetone_decode u_analog_side (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .level_code (analog_sidetone_level),
    .sidetone   (analog_sidetone)
  );

  cgrr_sidetone_decode u_digital_side (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .level_code (digital_sidetone_level),
    .sidetone   (digital_sidetone)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (addr_is(s_axi_araddr, OFS_GAIN_SHARED) || addr_is(s_axi_araddr, OFS_ROUTE_SHARED)) begin
      // write-only selectors read as zero
      next_rdata = '0;
    end else if (addr_is(s_axi_araddr, OFS_DAC_GAIN)) begin
      next_rdata = pack_byte(PFX_DAC, dac_attenuation_code);
    end else if (addr_is(s_axi_araddr, OFS_SIDETONE)) begin
      next_rdata = pack_byte(PFX_SIDE, {analog_sidetone_level, digital_sidetone_level});
    end else if (addr_is(s_axi_araddr, OFS_SPEAKER)) begin
      next_rdata = pack_byte(PFX_SPK, {speaker_boost, 4'h0});
    end else if (addr_is(s_axi_araddr, OFS_ROUTING)) begin
      next_rdata = {24'h000000, PFX_ROUTE, route_bits};
    end else if (addr_is(s_axi_araddr, OFS_STATUS)) begin
      next_rdata[STAT_DAC_LSB +: 8] = dac_path;
      next_rdata[STAT_AST_LSB +: 6] = analog_sidetone;
      next_rdata[STAT_DST_LSB +: 6] = digital_sidetone;
      next_rdata[STAT_SPK_LSB +: 2] = speaker_boost;
    end else begin
      next_rresp = RESP_DECERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // data is caught at the address take and held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

//--- sim/cgrr_regs_sva.sv
`timescale 1ns/1ps
module cgrr_regs_sva (
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [cgrr_pkg::DATA_W-1:0]   s_axi_rdata,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire cgrr_pkg::cgrr_dac_type        dac_path,
  input wire cgrr_pkg::cgrr_side_type       analog_sidetone,
  input wire cgrr_pkg::cgrr_side_type       digital_sidetone,
  input wire logic [1:0]                    speaker_boost,
  input wire cgrr_pkg::cgrr_route_type      input_route
);
  import cgrr_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // decoded outputs only ever take documented attenuation values
  property p_dac_mute;
    dac_path.mute |-> dac_path.atten_half_db == 7'h00;
  endproperty
  a_dac_mute: assert property (p_dac_mute) else $error("dac mute with attenuation");
  property p_dac_step;
    !dac_path.mute |-> (dac_path.atten_half_db <= 7'h51 && dac_path.atten_half_db % 3 == 0)
      || dac_path.atten_half_db inside {7'h54, 7'h60, 7'h6C};
  endproperty
  a_dac_step: assert property (p_dac_step) else $error("dac off grid");
  property p_side_map(cgrr_side_type st);
    st.mute ? st.atten_db == 5'h00
      : (st.atten_db >= 5'h09 && st.atten_db <= 5'h1B && st.atten_db % 3 == 0);
  endproperty
  a_ast_map: assert property (p_side_map(analog_sidetone)) else $error("ast map");
  a_dst_map: assert property (p_side_map(digital_sidetone)) else $error("dst map");
  // outputs move only alongside a write response, never on reads
  property p_out_cause;
    $past(aresetn)
      && !$stable({dac_path, analog_sidetone, digital_sidetone, speaker_boost, input_route})
      |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output moved, no write");
  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not released");
  c_dac_mute: cover property (dac_path.mute);
  c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
  c_loop: cover property (input_route.headset_loopback);
endmodule
bind cgrr_regs cgrr_regs_sva u_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .dac_path, .analog_sidetone,
  .digital_sidetone, .speaker_boost, .input_route
);

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cgrr_pkg::*;
  logic           aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic           s_axi_rvalid, s_axi_rready;
  logic [7:0]     s_axi_awaddr, s_axi_araddr;
  logic [2:0]     s_axi_awprot, s_axi_arprot;
  logic [31:0]    s_axi_wdata, s_axi_rdata, r;
  logic [3:0]     s_axi_wstrb;
  logic [1:0]     s_axi_bresp, s_axi_rresp, speaker_boost, m_spk;
  cgrr_dac_type   dac_path;
  cgrr_side_type  analog_sidetone, digital_sidetone;
  cgrr_route_type input_route;
  logic [5:0]     m_dac;
  logic [2:0]     m_ast, m_dst;
  logic [6:0]     m_route;
  logic [1:0]     bq[$];
  logic [33:0]    rq[$];
  int             failures = 0, num_checks = 0, i;
  int             seed = 32'h6E37;
  cgrr_regs dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dac_path, .analog_sidetone,
    .digital_sidetone, .speaker_boost, .input_route
  );
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // expected values from the gain tables
  function automatic cgrr_dac_type exp_dac(input logic [5:0] c);
    exp_dac = '0;
    if (c[4:0] == 5'h1F) exp_dac.mute = 1'b1;
    else if (c[4:0] <= 5'h1B) exp_dac.atten_half_db = 7'(c[4:0]) * 7'h03;
    else exp_dac.atten_half_db = (c[4:0] == 5'h1C) ? 7'h54 : (c[4:0] == 5'h1D) ? 7'h60 : 7'h6C;
  endfunction
  function automatic cgrr_side_type exp_side(input logic [2:0] c);
    exp_side = (c == 3'h7) ? 6'h20 : {1'b0, 5'h09 + 5'(c) * 5'h03};
  endfunction
  function automatic logic [33:0] exp_rd(input logic [7:0] a);
    case (a)
      OFS_GAIN_SHARED, OFS_ROUTE_SHARED: exp_rd = {RESP_OKAY, 32'h0};
      OFS_DAC_GAIN: exp_rd = {RESP_OKAY, 24'h0, 2'h1, m_dac};
      OFS_SIDETONE: exp_rd = {RESP_OKAY, 24'h0, 2'h2, m_ast, m_dst};
      OFS_SPEAKER:  exp_rd = {RESP_OKAY, 24'h0, 2'h3, m_spk, 4'h0};
      OFS_ROUTING:  exp_rd = {RESP_OKAY, 24'h0, 1'b0, m_route};
      OFS_STATUS:   exp_rd = {RESP_OKAY, 10'h0, m_spk, exp_side(m_dst), exp_side(m_ast),
                              exp_dac(m_dac)};
      default:      exp_rd = {RESP_DECERR, 32'h0};
    endcase
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_out;
    @(negedge aclk);
    chk(34'(dac_path), 34'(exp_dac(m_dac)));
    chk(34'(analog_sidetone), 34'(exp_side(m_ast)));
    chk(34'(digital_sidetone), 34'(exp_side(m_dst)));
    chk(34'(speaker_boost), 34'(m_spk));
    chk(34'(input_route), 34'(m_route));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // bus master; ready is looked at mid-cycle, where it is settled for the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    logic aw_pend, w_pend, aw_hit, w_hit, hit;
    logic [31:0] rnd;
    rnd = $random(seed);
    bq.push_back((a == OFS_GAIN_SHARED || a == OFS_ROUTE_SHARED) ? RESP_OKAY :
      (a inside {OFS_DAC_GAIN, OFS_SIDETONE, OFS_SPEAKER, OFS_ROUTING, OFS_STATUS}) ?
      RESP_SLVERR : RESP_DECERR);
    if (s[0] && a == OFS_GAIN_SHARED && d[7:6] == PFX_DAC) m_dac = d[5:0];
    if (s[0] && a == OFS_GAIN_SHARED && d[7:6] == PFX_SIDE) m_ast = d[5:3];
    if (s[0] && a == OFS_GAIN_SHARED && d[7:6] == PFX_SIDE) m_dst = d[2:0];
    if (s[0] && a == OFS_GAIN_SHARED && d[7:6] == PFX_SPK) m_spk = d[5:4];
    if (s[0] && a == OFS_ROUTE_SHARED && !d[7]) m_route = d[6:0];
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    while (aw_pend || w_pend) begin
      @(negedge aclk);
      aw_hit = aw_pend && s_axi_awready;
      w_hit = w_pend && s_axi_wready;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      aw_pend = aw_pend && !aw_hit;
      w_pend = w_pend && !w_hit;
    end
    // random stall on bready exercises the response hold
    repeat (rnd[1:0]) @(posedge aclk);
    s_axi_bready <= 1'b1;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = s_axi_bvalid;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge aclk);
    check_out;
  endtask
  task automatic rd(input logic [7:0] a);
    logic hit;
    logic [31:0] rnd;
    rnd = $random(seed);
    rq.push_back(exp_rd(a));
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    repeat (rnd[1:0]) @(posedge aclk);
    s_axi_rready <= 1'b1;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = s_axi_rvalid;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_all;
    for (int k = 0; k < 7; k++) rd(8'(4 * k));
  endtask
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    {m_dac, m_ast, m_dst, m_spk, m_route} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_out;
    rd_all;
    $display("test reset done");
    for (i = 0; i < 64; i++) wr(OFS_GAIN_SHARED, {2'h1, 6'(i)}, 4'hF);
    rd_all;
    $display("test dac gain done");
    for (i = 0; i < 8; i++) begin
      wr(OFS_GAIN_SHARED, {2'h2, 3'(i), 3'(i) ^ 3'h5}, 4'hF);
    end
    $display("test sidetone done");
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(OFS_GAIN_SHARED, {2'h3, 2'(i), r[3:0]}, 4'hF);
      rd(OFS_SPEAKER);
    end
    $display("test speaker done");
    for (i = 0; i < 4; i++) begin
      wr(OFS_ROUTE_SHARED, 8'h01 << i, 4'hF);
    end
    for (i = 4; i < 7; i++) begin
      wr(OFS_ROUTE_SHARED, 8'h01 << i, 4'hF);
    end
    wr(OFS_ROUTE_SHARED, 8'hFF, 4'hF);
    rd_all;
    $display("test routing done");
    // refused writes must leave every field alone
    wr(8'h40, 8'h7F, 4'hF);
    wr(OFS_DAC_GAIN, 8'h5F, 4'hF);
    wr(OFS_GAIN_SHARED, 8'h3F, 4'hF);
    wr(OFS_GAIN_SHARED, 8'h5F, 4'hE);
    rd(8'h40);
    rd(8'h02);
    $display("test refusals done");
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      wr(r[8] ? OFS_ROUTE_SHARED : OFS_GAIN_SHARED, r[7:0], 4'hF);
    end
    rd_all;
    $display("test random done");
    @(posedge aclk);
    aresetn <= 1'b0;
    {m_dac, m_ast, m_dst, m_spk, m_route} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_out;
    rd_all;
    $display("test second reset done");
    test_done;
  end
endmodule
